// *** shared/sdr_pkg.sv ***
// package of offsets, fields and types for the segment display register bank
package sdr_pkg;
   localparam logic [7:0]  OFS_IRQ_FLAG       = 8'h1c;
   localparam logic [7:0]  OFS_IRQ_FLAG_SET   = 8'h20;
   localparam logic [7:0]  OFS_IRQ_FLAG_CLEAR = 8'h24;
   localparam logic [7:0]  OFS_IRQ_ENABLE     = 8'h28;
   localparam logic [7:0]  OFS_SEG0           = 8'h40;
   localparam logic [7:0]  OFS_SEG1           = 8'h44;
   localparam logic [7:0]  OFS_SEG2           = 8'h48;
   localparam logic [7:0]  OFS_SEG3           = 8'h4c;
   localparam logic [7:0]  OFS_UPDATE_HOLD    = 8'h60;
   localparam logic [7:0]  OFS_SYNC_PENDING   = 8'h64;
   localparam logic [7:0]  OFS_SEG4           = 8'hcc;
   localparam logic [7:0]  OFS_SEG5           = 8'hd0;
   localparam logic [7:0]  OFS_SEG6           = 8'hd4;
   localparam logic [7:0]  OFS_SEG7           = 8'hd8;
   localparam int          SEG_W              = 24;
   localparam int          NUM_COM            = 8;
   localparam int          BIT_FRAME_EVENT    = 0;
   localparam int          BIT_UPDATE_HOLD    = 0;
   localparam int          BUSY_SEG_LO        = 4;
   localparam int          BUSY_SEG_HI        = 16;
   localparam logic [23:0] SEG_RESET          = 24'h000000;
   // display tick every 25 MHz / 32768 Hz, rounded down
   localparam int          CLK_HZ             = 25000000;
   localparam int          DISP_HZ            = 32768;
   localparam int          DISP_DIV           = CLK_HZ / DISP_HZ;
   localparam int          SYNC_TICKS         = 2;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } sdr_wb_req_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } sdr_wb_rsp_t;

   typedef logic [SEG_W-1:0] sdr_seg_t;
endpackage

// *** rtl/sdr_reg_bank.sv ***
// wishbone register bank of the segment display driver with display domain transfer
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - writing one to set register bit 0 sets the frame event flag
// - writing one to clear register bit 0 clears the frame event flag
// - enable bit 0 is read/write, resets zero, gates flag onto interrupt
// - eight 24-bit segment words, one per common line, reset to zero
// - while update hold is one, writes are not carried to display domain
// - while update hold is zero, writes transfer to display domain promptly
// - busy bits 0..3 show control, blink/anim, anim A, anim B syncing
// - busy bits 4..7 and 16..19 show segment words 0..7 syncing
// - frame event flag is set by hardware when frame counter reaches zero
module sdr_reg_bank (
   input  wire logic                                  clk,
   input  wire logic                                  resetn,
   input  wire sdr_pkg::sdr_wb_req_t                  wb_req,
   output sdr_pkg::sdr_wb_rsp_t                       wb_rsp,
   input  wire logic                                  frame_event,
   input  wire logic [3:0]                            ctl_write_pulse,
   output logic                                       irq,
   output logic                                       disp_tick,
   output logic [sdr_pkg::NUM_COM*sdr_pkg::SEG_W-1:0] disp_seg_words,
   output logic [3:0]                                 ctl_apply_pulse
);
   import sdr_pkg::*;

   sdr_seg_t    seg_reg [NUM_COM];
   sdr_seg_t    disp_reg [NUM_COM];
   logic [NUM_COM-1:0] seg_pend_reg;
   logic [3:0]  ctl_pend_reg;
   logic        flag_reg;
   logic        enable_reg;
   logic        hold_reg;
   logic        ack_reg;
   logic [31:0] rdat_reg;
   logic [31:0] rdat_next;
   logic [15:0] div_reg;
   logic [1:0]  sync_cnt_reg;
   logic        wr;
   logic        rd;
   logic        wbit0;
   logic [NUM_COM-1:0] seg_hit;
   logic [31:0] busy;
   logic        apply;
   logic [10:0] xfer_wait_reg;

   assign rd = wb_req.cyc & wb_req.stb & ~wb_req.we & ~ack_reg;
   assign wr = wb_req.cyc & wb_req.stb & wb_req.we & ~ack_reg;
   assign wbit0 = wr & wb_req.sel[0] & wb_req.dat[0];

   always_comb begin
      seg_hit = '0;
      case (wb_req.adr)
         OFS_SEG0: seg_hit[0] = wr;
         OFS_SEG1: seg_hit[1] = wr;
         OFS_SEG2: seg_hit[2] = wr;
         OFS_SEG3: seg_hit[3] = wr;
         OFS_SEG4: seg_hit[4] = wr;
         OFS_SEG5: seg_hit[5] = wr;
         OFS_SEG6: seg_hit[6] = wr;
         OFS_SEG7: seg_hit[7] = wr;
         default: seg_hit = '0;
      endcase
   end

   // wishbone ack one cycle after request, dropped next cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= (rd | wr);
      end
   end

   // segment words with byte lanes
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < NUM_COM; i++) seg_reg[i] <= SEG_RESET;
      end else begin
         for (int i = 0; i < NUM_COM; i++) begin
            for (int b = 0; b < 3; b++) begin
               if (seg_hit[i] && wb_req.sel[b]) begin
                  seg_reg[i][b*8 +: 8] <= wb_req.dat[b*8 +: 8];
               end
            end
         end
      end
   end

   // frame event flag: hardware and software set win over clear
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         flag_reg <= 1'b0;
      end else if (frame_event) begin
         flag_reg <= 1'b1;
      end else if (wbit0 && wb_req.adr == OFS_IRQ_FLAG_SET) begin
         flag_reg <= 1'b1;
      end else if (wbit0 && wb_req.adr == OFS_IRQ_FLAG_CLEAR) begin
         flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         enable_reg <= 1'b0;
         hold_reg   <= 1'b0;
      end else if (wr && wb_req.sel[0]) begin
         if (wb_req.adr == OFS_IRQ_ENABLE) enable_reg <= wb_req.dat[BIT_FRAME_EVENT];
         if (wb_req.adr == OFS_UPDATE_HOLD) hold_reg <= wb_req.dat[BIT_UPDATE_HOLD];
      end
   end

   assign irq = flag_reg & enable_reg;

   // display clock enable and synchroniser delay
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         div_reg <= '0;
      end else if (div_reg == 16'(DISP_DIV - 1)) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_reg + 16'h0001;
      end
   end
   assign disp_tick = (div_reg == 16'(DISP_DIV - 1));

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sync_cnt_reg <= '0;
      end else if (hold_reg || ((seg_pend_reg == '0) && (ctl_pend_reg == '0))) begin
         sync_cnt_reg <= '0;
      end else if (disp_tick) begin
         sync_cnt_reg <= (sync_cnt_reg == 2'(SYNC_TICKS - 1)) ? 2'h0 : sync_cnt_reg + 2'h1;
      end
   end
   assign apply = ~hold_reg & disp_tick & (sync_cnt_reg == 2'(SYNC_TICKS - 1));

   // pending flags: a new write wins over the apply in the same cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         seg_pend_reg <= '0;
         ctl_pend_reg <= '0;
      end else begin
         seg_pend_reg <= (apply ? '0 : seg_pend_reg) | seg_hit;
         ctl_pend_reg <= (apply ? '0 : ctl_pend_reg) | ctl_write_pulse;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < NUM_COM; i++) disp_reg[i] <= SEG_RESET;
         ctl_apply_pulse <= '0;
      end else begin
         ctl_apply_pulse <= apply ? ctl_pend_reg : 4'h0;
         for (int i = 0; i < NUM_COM; i++) begin
            if (apply && seg_pend_reg[i]) disp_reg[i] <= seg_reg[i];
         end
      end
   end

   always_comb begin
      for (int i = 0; i < NUM_COM; i++) disp_seg_words[i*SEG_W +: SEG_W] = disp_reg[i];
   end

   always_comb begin
      busy = '0;
      busy[3:0] = ctl_pend_reg;
      busy[BUSY_SEG_LO +: 4] = seg_pend_reg[3:0];
      busy[BUSY_SEG_HI +: 4] = seg_pend_reg[7:4];
   end

   always_comb begin
      rdat_next = '0;
      case (wb_req.adr)
         OFS_IRQ_FLAG:     rdat_next[0] = flag_reg;
         OFS_IRQ_ENABLE:   rdat_next[0] = enable_reg;
         OFS_UPDATE_HOLD:  rdat_next[0] = hold_reg;
         OFS_SYNC_PENDING: rdat_next = busy;
         OFS_SEG0:         rdat_next[SEG_W-1:0] = seg_reg[0];
         OFS_SEG1:         rdat_next[SEG_W-1:0] = seg_reg[1];
         OFS_SEG2:         rdat_next[SEG_W-1:0] = seg_reg[2];
         OFS_SEG3:         rdat_next[SEG_W-1:0] = seg_reg[3];
         OFS_SEG4:         rdat_next[SEG_W-1:0] = seg_reg[4];
         OFS_SEG5:         rdat_next[SEG_W-1:0] = seg_reg[5];
         OFS_SEG6:         rdat_next[SEG_W-1:0] = seg_reg[6];
         OFS_SEG7:         rdat_next[SEG_W-1:0] = seg_reg[7];
         default:          rdat_next = '0;
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdat_reg <= '0;
      end else if (rd) begin
         rdat_reg <= rdat_next;
      end
   end

   assign wb_rsp.ack = ack_reg;
   assign wb_rsp.dat = rdat_reg;

   // checks
   property p_set;
      @(posedge clk) disable iff (!resetn)
      (wbit0 && wb_req.adr == OFS_IRQ_FLAG_SET) |=> flag_reg;
   endproperty
   a_set: assert property (p_set) else $error("flag not set");

   property p_clr;
      @(posedge clk) disable iff (!resetn)
      (wbit0 && wb_req.adr == OFS_IRQ_FLAG_CLEAR && !frame_event) |=> !flag_reg;
   endproperty
   a_clr: assert property (p_clr) else $error("flag not cleared");

   property p_irq;
      @(posedge clk) disable iff (!resetn)
      irq && !(wr && wb_req.sel[0] &&
         (wb_req.adr == OFS_IRQ_FLAG_CLEAR || wb_req.adr == OFS_IRQ_ENABLE)) |=> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq dropped while flag and enable set");

   property p_en;
      @(posedge clk) disable iff (!resetn)
      (wr && wb_req.sel[0] && wb_req.adr == OFS_IRQ_ENABLE) |=> enable_reg == $past(wb_req.dat[0]);
   endproperty
   a_en: assert property (p_en) else $error("enable not written");

   property p_hold;
      @(posedge clk) disable iff (!resetn)
      hold_reg |=> $stable(disp_seg_words);
   endproperty
   a_hold: assert property (p_hold) else $error("display changed under hold");

   // cycles that pending word 0 has waited with hold low, saturating
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         xfer_wait_reg <= '0;
      end else if (!seg_pend_reg[0] || hold_reg || seg_hit[0]) begin
         xfer_wait_reg <= '0;
      end else if (xfer_wait_reg != 11'h7ff) begin
         xfer_wait_reg <= xfer_wait_reg + 11'h001;
      end
   end

   property p_xfer;
      @(posedge clk) disable iff (!resetn)
      xfer_wait_reg <= 11'(SYNC_TICKS * DISP_DIV);
   endproperty
   a_xfer: assert property (p_xfer) else $error("transfer stalled");

   property p_busy;
      @(posedge clk) disable iff (!resetn)
      seg_hit[5] |=> busy[17] && wb_rsp.ack;
   endproperty
   a_busy: assert property (p_busy) else $error("busy not raised");

   property p_ctl;
      @(posedge clk) disable iff (!resetn)
      ctl_write_pulse[1] |=> busy[1];
   endproperty
   a_ctl: assert property (p_ctl) else $error("control busy not raised");

   property p_seg;
      @(posedge clk) disable iff (!resetn)
      (seg_hit[2] && wb_req.sel == 4'hf) |=> seg_reg[2] == $past(wb_req.dat[23:0]);
   endproperty
   a_seg: assert property (p_seg) else $error("segment word not stored");

   property p_evt;
      @(posedge clk) disable iff (!resetn)
      frame_event |=> flag_reg;
   endproperty
   a_evt: assert property (p_evt) else $error("frame event lost");

   property p_pend_hold;
      @(posedge clk) disable iff (!resetn)
      hold_reg && seg_pend_reg[2] |=> seg_pend_reg[2];
   endproperty
   a_pend_hold: assert property (p_pend_hold) else $error("pending word lost under hold");

   property p_ctl_apply;
      @(posedge clk) disable iff (!resetn)
      (ctl_apply_pulse != 4'h0) |-> !$past(hold_reg);
   endproperty
   a_ctl_apply: assert property (p_ctl_apply) else $error("control applied under hold");

   property p_xfer_val;
      @(posedge clk) disable iff (!resetn)
      $fell(seg_pend_reg[5]) |-> disp_seg_words[5*SEG_W +: SEG_W] == seg_reg[5];
   endproperty
   a_xfer_val: assert property (p_xfer_val) else $error("word not transferred");

   c_irq: cover property (@(posedge clk) disable iff (!resetn) $rose(irq));
   c_apply: cover property (@(posedge clk) disable iff (!resetn) apply && seg_pend_reg != '0);
   c_hold: cover property (@(posedge clk) disable iff (!resetn) $fell(hold_reg) && seg_pend_reg != '0);
   c_ctl: cover property (@(posedge clk) disable iff (!resetn) ctl_apply_pulse[3]);
   c_evt: cover property (@(posedge clk) disable iff (!resetn) frame_event && !enable_reg);
endmodule
`default_nettype wire

// *** test/sdr_glass_model.sv ***
// partner model: frame counter raising frame events from display ticks
`timescale 1ns/1ps
`default_nettype none
module sdr_glass_model (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic disp_tick,
   input  wire logic run,
   output logic      frame_event
);
   logic [1:0] frame_cnt_reg;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         frame_cnt_reg <= 2'h0;
         frame_event   <= 1'b0;
      end else begin
         frame_event <= run && disp_tick && frame_cnt_reg == 2'h0;
         if (disp_tick) begin
            frame_cnt_reg <= frame_cnt_reg + 2'h1;
         end
      end
   end
endmodule
`default_nettype wire

// *** test/testbench.sv ***
// self-checking bench of the segment display register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import sdr_pkg::*;
   logic                     clk;
   logic                     resetn;
   sdr_wb_req_t              wb_req;
   sdr_wb_rsp_t              wb_rsp;
   logic                     frame_event;
   logic [3:0]               ctl_write_pulse;
   logic                     irq;
   logic                     disp_tick;
   logic [NUM_COM*SEG_W-1:0] disp_seg_words;
   logic [3:0]               ctl_apply_pulse;
   logic                     run;
   int                       n_errors;
   int                       tests_run;
   logic [31:0]              q;
   logic [7:0]               seg_ofs [8];
   sdr_reg_bank i_sdr_reg_bank (.clk(clk), .resetn(resetn), .wb_req(wb_req), .wb_rsp(wb_rsp),
      .frame_event(frame_event), .ctl_write_pulse(ctl_write_pulse), .irq(irq),
      .disp_tick(disp_tick), .disp_seg_words(disp_seg_words), .ctl_apply_pulse(ctl_apply_pulse));
   sdr_glass_model i_sdr_glass_model (.clk(clk), .resetn(resetn), .disp_tick(disp_tick),
      .run(run), .frame_event(frame_event));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      wb_req <= '{1'b1, 1'b1, we, a, 4'hf, d};
      do begin
         @(posedge clk);
         n++;
      end while (wb_rsp.ack !== 1'b1 && n < 50);
      q = wb_rsp.dat;
      wb_req <= '0;
      chk(32'(n < 50), 32'h1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   function automatic logic [31:0] bb(input int i);
      return 32'h1 << (i < 4 ? BUSY_SEG_LO + i : BUSY_SEG_HI + i - 4);
   endfunction
   function automatic logic [23:0] sv(input int i);
      return {8'(8'h30 + i), 16'ha5c3};
   endfunction
   function automatic logic [23:0] dw(input int i);
      return disp_seg_words[i*SEG_W +: SEG_W];
   endfunction
   task automatic wait_idle(input logic [31:0] m);
      int n;
      n = 0;
      do begin
         bus(1'b0, OFS_SYNC_PENDING, 32'h0);
         n++;
      end while ((q & m) !== 32'h0 && n < 1000);
      chk(q & m, 32'h0);
   endtask
   task automatic t_reset();
      for (int i = 0; i < 8; i++) rd(seg_ofs[i], 32'h0);
      rd(OFS_IRQ_ENABLE, 32'h0);
      rd(OFS_SYNC_PENDING, 32'h0);
      rd(OFS_UPDATE_HOLD, 32'h0);
      rd(OFS_IRQ_FLAG_SET, 32'h0);
      chk(32'(irq), 32'h0);
      bus(1'b1, 8'h80, 32'h5);
      rd(8'h80, 32'h0);
      $display("reset test done");
   endtask
   task automatic t_irq();
      int n;
      n = 0;
      run <= 1'b1;
      do begin
         bus(1'b0, OFS_IRQ_FLAG, 32'h0);
         n++;
      end while (q !== 32'h1 && n < 2000);
      run <= 1'b0;
      chk(q, 32'h1);
      chk(32'(irq), 32'h0);
      bus(1'b1, OFS_IRQ_ENABLE, 32'h1);
      chk(32'(irq), 32'h1);
      bus(1'b1, OFS_IRQ_FLAG_CLEAR, 32'h0);
      chk(32'(irq), 32'h1);
      bus(1'b1, OFS_IRQ_FLAG_CLEAR, 32'h1);
      chk(32'(irq), 32'h0);
      bus(1'b1, OFS_IRQ_FLAG_SET, 32'h0);
      chk(32'(irq), 32'h0);
      bus(1'b1, OFS_IRQ_FLAG_SET, 32'h1);
      chk(32'(irq), 32'h1);
      rd(OFS_IRQ_ENABLE, 32'h1);
      bus(1'b1, OFS_IRQ_ENABLE, 32'h0);
      chk(32'(irq), 32'h0);
      rd(OFS_IRQ_FLAG, 32'h1);
      $display("interrupt test done");
   endtask
   task automatic t_seg();
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, seg_ofs[i], {8'h00, sv(i)});
         rd(OFS_SYNC_PENDING, bb(i));
         wait_idle(bb(i));
         chk({8'h0, dw(i)}, {8'h0, sv(i)});
         rd(seg_ofs[i], {8'h0, sv(i)});
      end
      $display("segment test done");
   endtask
   task automatic t_hold();
      int n;
      n = 0;
      bus(1'b1, OFS_UPDATE_HOLD, 32'h1);
      bus(1'b1, OFS_SEG2, 32'h00123456);
      bus(1'b1, OFS_SEG5, 32'h00654321);
      repeat (1600) @(posedge clk);
      rd(OFS_SYNC_PENDING, bb(2) | bb(5));
      chk({8'h0, dw(2)}, {8'h0, sv(2)});
      bus(1'b1, OFS_UPDATE_HOLD, 32'h0);
      while (dw(2) !== 24'h123456 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      chk({8'h0, dw(5)}, 32'h00654321);
      chk({8'h0, dw(2)}, 32'h00123456);
      wait_idle(bb(2) | bb(5));
      $display("hold test done");
   endtask
   task automatic t_ctl();
      int n;
      for (int b = 0; b < 4; b++) begin
         @(posedge clk);
         ctl_write_pulse <= 4'(1 << b);
         @(posedge clk);
         ctl_write_pulse <= 4'h0;
         rd(OFS_SYNC_PENDING, 32'(1 << b));
         n = 0;
         do begin
            @(posedge clk);
            n++;
         end while (ctl_apply_pulse[b] !== 1'b1 && n < 3000);
         chk(32'(n < 3000), 32'h1);
         wait_idle(32'(1 << b));
      end
      $display("control busy test done");
   endtask
   task automatic t_tick();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (disp_tick !== 1'b1 && n < 2000);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (disp_tick !== 1'b1 && n < 2000);
      chk(32'(n), 32'(DISP_DIV));
      $display("display tick test done");
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      #(60000 * 40);
      n_errors++;
      close_out();
   end
   initial begin
      resetn = 1'b0;
      wb_req = '0;
      ctl_write_pulse = 4'h0;
      run = 1'b0;
      n_errors = 0;
      tests_run = 0;
      seg_ofs = '{OFS_SEG0, OFS_SEG1, OFS_SEG2, OFS_SEG3, OFS_SEG4, OFS_SEG5, OFS_SEG6, OFS_SEG7};
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      t_reset();
      t_tick();
      t_irq();
      t_seg();
      t_hold();
      t_ctl();
      close_out();
   end
endmodule
`default_nettype wire
